/* File: design/emb_pkg.sv */
// constants, register map and types for the emulation memory board host controller
// assumes a 20 MHz clock and one board of asynchronous static ram on the memory bus
package emb_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int ID_W = 9;
    localparam int AVS_ADDR_W = 5;

    // avalon byte addresses
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_RDATA = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_ID = 5'h14;

    // field positions
    localparam int CTRL_GO = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_BE_LSB = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;

    // reset values
    localparam logic [ADDR_W-1:0] RST_ADDR = 19'h00000;
    localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
    localparam logic [ID_W-1:0] RST_ID = 9'h000;
    localparam logic [1:0] RST_BE = 2'h3;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int ACCESS_NS = 70;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC = 2;

    typedef enum logic [1:0] {
        EMB_OP_READ = 2'h0,
        EMB_OP_WRITE = 2'h1,
        EMB_OP_ID = 2'h2
    } emb_op_t;

    typedef enum logic [1:0] {
        EMB_IDLE = 2'h0,
        EMB_SETUP = 2'h1,
        EMB_STROBE = 2'h3,
        EMB_HOLD = 2'h2
    } emb_state_t;
endpackage

/* File: design/emb_seq_if.sv */
// request and answer between the register front end and the pin sequencer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface emb_seq_if;
    logic req;
    emb_pkg::emb_op_t op;
    logic [emb_pkg::ADDR_W-1:0] addr;
    logic [emb_pkg::DATA_W-1:0] wdata;
    logic [1:0] be;
    logic busy;
    logic done;
    logic [emb_pkg::DATA_W-1:0] rdata;
    logic [emb_pkg::ID_W-1:0] id;

    modport ctl (output req, op, addr, wdata, be, input busy, done, rdata, id);
    modport seq (input req, op, addr, wdata, be, output busy, done, rdata, id);
endinterface

/* File: design/emb_pin_seq.sv */
// pin sequencer: runs one ram read, ram write or id read on the board pins
// assumes pin inputs are asynchronous to clock; all pin outputs come from flip-flops
`timescale 1ns/100ps
module emb_pin_seq #(
    parameter int ACCESS_CYC = emb_pkg::ACCESS_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    emb_seq_if.seq sq,
    output logic [emb_pkg::ADDR_W-1:0] mem_addr_n,
    input wire logic [emb_pkg::DATA_W-1:0] emu_data_bus_n_in,
    output logic [emb_pkg::DATA_W-1:0] emu_data_bus_n_out,
    output logic emu_data_bus_n_oe,
    output logic read_not_write,
    output logic write_low_byte_n,
    output logic write_high_byte_n,
    output logic id_enable_n,
    output logic slot_select_n,
    output logic cpu_strobe_n,
    input wire logic [emb_pkg::ID_W-1:0] id_data_n
);
    // read data must settle through the ram and the two-stage synchroniser
    localparam int WAIT_CYC = ACCESS_CYC + emb_pkg::SYNC_CYC;
    localparam logic [3:0] WAIT_LAST = 4'(WAIT_CYC - 1);

    initial begin
        if (ACCESS_CYC < 1 || WAIT_CYC > 16) begin
            $error("emb_pin_seq: ACCESS_CYC out of range");
        end
    end

    emb_pkg::emb_state_t state_r;
    emb_pkg::emb_op_t op_r;
    logic [3:0] cnt_r;
    logic [emb_pkg::DATA_W-1:0] data_meta_r, data_sync_r;
    logic [emb_pkg::ID_W-1:0] id_meta_r, id_sync_r;
    logic done_r;
    logic [emb_pkg::DATA_W-1:0] rdata_r;
    logic [emb_pkg::ID_W-1:0] id_r;

    assign sq.busy = (state_r != emb_pkg::EMB_IDLE);
    assign sq.done = done_r;
    assign sq.rdata = rdata_r;
    assign sq.id = id_r;

    always_ff @(posedge clock) begin
        data_meta_r <= emu_data_bus_n_in;
        data_sync_r <= data_meta_r;
        id_meta_r <= id_data_n;
        id_sync_r <= id_meta_r;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= emb_pkg::EMB_IDLE;
            op_r <= emb_pkg::EMB_OP_READ;
            cnt_r <= 4'h0;
        end else begin
            case (state_r)
                emb_pkg::EMB_IDLE: begin
                    if (sq.req) begin
                        state_r <= emb_pkg::EMB_SETUP;
                        op_r <= sq.op;
                    end
                end
                emb_pkg::EMB_SETUP: begin
                    state_r <= emb_pkg::EMB_STROBE;
                    cnt_r <= 4'h0;
                end
                emb_pkg::EMB_STROBE: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == WAIT_LAST) begin
                        state_r <= emb_pkg::EMB_HOLD;
                    end
                end
                default: begin
                    state_r <= emb_pkg::EMB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mem_addr_n <= '1;
            emu_data_bus_n_out <= '1;
            emu_data_bus_n_oe <= 1'b0;
            read_not_write <= 1'b1;
            write_low_byte_n <= 1'b1;
            write_high_byte_n <= 1'b1;
            id_enable_n <= 1'b1;
            slot_select_n <= 1'b1;
            cpu_strobe_n <= 1'b1;
        end else begin
            case (state_r)
                emb_pkg::EMB_IDLE: begin
                    // direction turns toward us only after our drivers are off
                    read_not_write <= 1'b1;
                    if (sq.req && sq.op != emb_pkg::EMB_OP_ID) begin
                        mem_addr_n <= ~sq.addr;
                        emu_data_bus_n_out <= ~sq.wdata;
                        if (sq.op == emb_pkg::EMB_OP_WRITE) begin
                            read_not_write <= 1'b0;
                            emu_data_bus_n_oe <= 1'b1;
                        end
                    end
                    if (sq.req && sq.op == emb_pkg::EMB_OP_ID) begin
                        slot_select_n <= 1'b0;
                        id_enable_n <= 1'b0;
                    end
                end
                emb_pkg::EMB_SETUP: begin
                    if (op_r == emb_pkg::EMB_OP_WRITE) begin
                        write_low_byte_n <= ~sq.be[0];
                        write_high_byte_n <= ~sq.be[1];
                    end
                    if (op_r == emb_pkg::EMB_OP_ID) begin
                        // low strobe on an id read: we have let go of the data bus
                        cpu_strobe_n <= 1'b0;
                    end
                end
                emb_pkg::EMB_STROBE: begin
                    if (cnt_r == WAIT_LAST) begin
                        write_low_byte_n <= 1'b1;
                        write_high_byte_n <= 1'b1;
                        cpu_strobe_n <= 1'b1;
                    end
                end
                default: begin
                    // data held one cycle past the strobes, then released
                    emu_data_bus_n_oe <= 1'b0;
                    id_enable_n <= 1'b1;
                    slot_select_n <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_r <= emb_pkg::RST_DATA;
            id_r <= emb_pkg::RST_ID;
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == emb_pkg::EMB_HOLD);
            if (state_r == emb_pkg::EMB_STROBE && cnt_r == WAIT_LAST) begin
                if (op_r == emb_pkg::EMB_OP_READ) begin
                    rdata_r <= ~data_sync_r;
                end
                if (op_r == emb_pkg::EMB_OP_ID) begin
                    id_r <= ~id_sync_r;
                end
            end
        end
    end
endmodule

/* File: design/emb_mem_host.sv */
// host controller for the emulation memory board: avalon-mm register front end
// assumes software on avalon-mm with waitrequest; board pins wired through emb_pin_seq
// Function
// - bus has 19 address, 16 data lines, direction and two byte strobes
// - controller drives address lines active low
// - direction low turns transceivers so controller data reaches the ram
// - low-byte strobe low writes data bits 0 to 7
// - high-byte strobe low writes data bits 8 to 15
// - strobe low means data valid on write, bus released on read
// - slot select buffer enabled only while slot select is low
// - alone, the compatibility jumper sits in its default lower position
`timescale 1ns/100ps
module emb_mem_host #(
    parameter int ACCESS_CYC = emb_pkg::ACCESS_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [emb_pkg::AVS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [emb_pkg::ADDR_W-1:0] mem_addr_n,
    input wire logic [emb_pkg::DATA_W-1:0] emu_data_bus_n_in,
    output logic [emb_pkg::DATA_W-1:0] emu_data_bus_n_out,
    output logic emu_data_bus_n_oe,
    output logic read_not_write,
    output logic write_low_byte_n,
    output logic write_high_byte_n,
    output logic id_enable_n,
    output logic slot_select_n,
    output logic cpu_strobe_n,
    input wire logic [emb_pkg::ID_W-1:0] id_data_n
);
    initial begin
        if (ACCESS_CYC < 1) begin
            $error("emb_mem_host: ACCESS_CYC must be at least 1");
        end
    end

    emb_seq_if sq ();

    logic [emb_pkg::ADDR_W-1:0] addr_r;
    logic [emb_pkg::DATA_W-1:0] wdata_r;
    logic [1:0] be_r;
    emb_pkg::emb_op_t op_r;
    logic req_r;
    logic done_r;
    logic take;
    logic wr_take;
    logic [31:0] rd_word;

    // merge a write into a register honouring avalon byte enables
    function automatic logic [31:0] emb_merge(input logic [31:0] old,
                                              input logic [31:0] din,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = din[8*i +: 8];
            end
        end
        return res;
    endfunction

    // a request is taken once, in the cycle it appears, and answered in the cycle after
    assign take = (avs_read || avs_write) && avs_waitrequest;
    assign wr_take = take && avs_write;

    assign sq.req = req_r;
    assign sq.op = op_r;
    assign sq.addr = addr_r;
    assign sq.wdata = wdata_r;
    assign sq.be = be_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~take;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            addr_r <= emb_pkg::RST_ADDR;
            wdata_r <= emb_pkg::RST_DATA;
        end else if (wr_take && avs_address == emb_pkg::REG_ADDR) begin
            // full 19-bit word address; no mixed-board remapping is done here
            addr_r <= emb_pkg::ADDR_W'(emb_merge(32'(addr_r), avs_writedata, avs_byteenable));
        end else if (wr_take && avs_address == emb_pkg::REG_WDATA) begin
            wdata_r <= emb_pkg::DATA_W'(emb_merge(32'(wdata_r), avs_writedata, avs_byteenable));
        end
    end

    // a control write while busy or pending is ignored whole, op and lanes included
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            req_r <= 1'b0;
            op_r <= emb_pkg::EMB_OP_READ;
            be_r <= emb_pkg::RST_BE;
        end else begin
            req_r <= 1'b0;
            if (wr_take && avs_address == emb_pkg::REG_CTRL && avs_byteenable[0]
                && !sq.busy && !req_r) begin
                op_r <= emb_pkg::emb_op_t'(avs_writedata[emb_pkg::CTRL_OP_LSB +: 2]);
                be_r <= avs_writedata[emb_pkg::CTRL_BE_LSB +: 2];
                req_r <= avs_writedata[emb_pkg::CTRL_GO];
            end
        end
    end

    // done is sticky; a new completion beats a write-one-to-clear in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            done_r <= 1'b0;
        end else if (sq.done) begin
            done_r <= 1'b1;
        end else if (wr_take && avs_address == emb_pkg::REG_STATUS && avs_byteenable[0]
                     && avs_writedata[emb_pkg::STAT_DONE]) begin
            done_r <= 1'b0;
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        if (avs_address == emb_pkg::REG_CTRL) begin
            rd_word[emb_pkg::CTRL_OP_LSB +: 2] = op_r;
            rd_word[emb_pkg::CTRL_BE_LSB +: 2] = be_r;
        end else if (avs_address == emb_pkg::REG_ADDR) begin
            rd_word = 32'(addr_r);
        end else if (avs_address == emb_pkg::REG_WDATA) begin
            rd_word = 32'(wdata_r);
        end else if (avs_address == emb_pkg::REG_RDATA) begin
            rd_word = 32'(sq.rdata);
        end else if (avs_address == emb_pkg::REG_STATUS) begin
            rd_word[emb_pkg::STAT_BUSY] = sq.busy | req_r;
            rd_word[emb_pkg::STAT_DONE] = done_r;
        end else if (avs_address == emb_pkg::REG_ID) begin
            rd_word = 32'(sq.id);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            avs_readdata <= 32'h00000000;
        end else if (take && avs_read) begin
            avs_readdata <= rd_word;
        end
    end

    emb_pin_seq #(
        .ACCESS_CYC(ACCESS_CYC)
    ) u_seq (
        .clock(clock),
        .sys_rst(sys_rst),
        .sq(sq.seq),
        .mem_addr_n(mem_addr_n),
        .emu_data_bus_n_in(emu_data_bus_n_in),
        .emu_data_bus_n_out(emu_data_bus_n_out),
        .emu_data_bus_n_oe(emu_data_bus_n_oe),
        .read_not_write(read_not_write),
        .write_low_byte_n(write_low_byte_n),
        .write_high_byte_n(write_high_byte_n),
        .id_enable_n(id_enable_n),
        .slot_select_n(slot_select_n),
        .cpu_strobe_n(cpu_strobe_n),
        .id_data_n(id_data_n)
    );
endmodule

/* File: testbench/emb_board_model.sv */
// behavioural emulation memory board: row decode, byte-lane ram, id code
// assumes host pins of emb_mem_host; the data bus is pulled up when undriven
`timescale 1ns/100ps
module emb_board_model #(
    parameter logic [2:0] RANGE = 3'h0,
    parameter int ROWS = 4,
    parameter logic [8:0] ID_BASE = 9'h0a5 // arbitrary value
) (
    input wire logic [18:0] mem_addr_n,
    input wire logic [15:0] bus_out_n,
    input wire logic bus_oe,
    input wire logic read_not_write,
    input wire logic write_low_byte_n,
    input wire logic write_high_byte_n,
    input wire logic id_enable_n,
    input wire logic slot_select_n,
    input wire logic cpu_strobe_n,
    output logic [15:0] bus_in_n,
    output logic [8:0] id_data_n
);
    localparam logic [8:0] ID_CODE = ID_BASE + 9'(ROWS == 4 ? 0 : ROWS == 2 ? 1 : 2);
    logic [15:0] mem [int];
    logic [18:0] a;
    logic [3:0] row_select_n;
    logic board_read_enable;
    logic xcvr_read_enable_n;
    assign a = ~mem_addr_n;
    // range jumper in its default position: this board owns one 64K range
    always_comb begin
        row_select_n = 4'hf;
        if (a[18:16] == RANGE && int'(a[15:14]) < ROWS) begin
            row_select_n[a[15:14]] = 1'b0;
        end
    end
    assign board_read_enable = ~&row_select_n;
    assign xcvr_read_enable_n = ~(board_read_enable & read_not_write);
    always_comb begin
        bus_in_n = 16'hffff;
        if (bus_oe) begin
            bus_in_n = bus_out_n;
        end else if (!xcvr_read_enable_n) begin
            bus_in_n = ~(mem.exists(a) ? mem[a] : 16'h0000);
        end
    end
    // ram latches data as the strobe ends, while address and data still hold
    always @(posedge write_low_byte_n)
        if (!read_not_write && board_read_enable) mem[a][7:0] = ~bus_in_n[7:0];
    always @(posedge write_high_byte_n)
        if (!read_not_write && board_read_enable) mem[a][15:8] = ~bus_in_n[15:8];
    // released lines show the inverse so a stale code cannot pass
    assign id_data_n = (!id_enable_n && !slot_select_n && !cpu_strobe_n) ? ~ID_CODE : ID_CODE;
endmodule

/* File: testbench/emb_mem_host_sva.sv */
// assertions on the host pins and the register bus handshake
// assumes it is bound into emb_mem_host and sees only its ports
`timescale 1ns/100ps
module emb_mem_host_sva #(
    parameter int ACCESS_CYC = 2
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [emb_pkg::ADDR_W-1:0] mem_addr_n,
    input wire logic [emb_pkg::DATA_W-1:0] emu_data_bus_n_out,
    input wire logic emu_data_bus_n_oe,
    input wire logic read_not_write,
    input wire logic write_low_byte_n,
    input wire logic write_high_byte_n,
    input wire logic id_enable_n,
    input wire logic slot_select_n,
    input wire logic cpu_strobe_n
);
    logic strb_n;
    logic [7:0] low_cnt_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    assign strb_n = write_low_byte_n & write_high_byte_n & cpu_strobe_n;
    // width counted here so the check needs no long repetition
    always_ff @(posedge clock) begin
        if (sys_rst || strb_n) begin
            low_cnt_r <= 8'h00;
        end else begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one cycle");
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_oe_dir_write: assert property (emu_data_bus_n_oe |-> !read_not_write)
        else $error("data driven while direction is read");
    a_strobe_dir: assert property (!(write_low_byte_n && write_high_byte_n) |-> emu_data_bus_n_oe && !read_not_write)
        else $error("byte strobe without write direction");
    a_strobe_width: assert property ($rose(strb_n) |-> low_cnt_r == ACCESS_CYC + 2)
        else $error("strobe width wrong");
    a_addr_data_hold: assert property (!strb_n && !$past(strb_n) |-> $stable(mem_addr_n) && $stable(emu_data_bus_n_out))
        else $error("address or data moved under strobe");
    a_setup_first: assert property ($fell(strb_n) |-> $stable(mem_addr_n) && $stable(read_not_write))
        else $error("strobe fell with address or direction");
    a_id_slot: assert property (!cpu_strobe_n |-> !slot_select_n && !id_enable_n)
        else $error("cpu strobe without slot and id enable");
    a_id_release: assert property ($rose(cpu_strobe_n) |=> slot_select_n && id_enable_n)
        else $error("slot or id enable not released");
    a_bus_release: assert property ($rose(strb_n) && !read_not_write |=> !emu_data_bus_n_oe ##1 read_not_write)
        else $error("data bus not released after write");
    cover property ($fell(write_low_byte_n) && !write_high_byte_n);
    cover property ($fell(write_high_byte_n) && write_low_byte_n);
    cover property ($fell(cpu_strobe_n));
    cover property (!avs_waitrequest && avs_read);
endmodule
bind emb_mem_host emb_mem_host_sva #(.ACCESS_CYC(ACCESS_CYC)) u_sva (.clock, .sys_rst, .avs_read,
    .avs_write, .avs_waitrequest, .mem_addr_n, .emu_data_bus_n_out, .emu_data_bus_n_oe,
    .read_not_write, .write_low_byte_n, .write_high_byte_n, .id_enable_n, .slot_select_n,
    .cpu_strobe_n);

/* File: testbench/emb_mem_host_tb.sv */
// self-checking bench: avalon register calls into emb_mem_host, board model on its pins
// assumes emb_board_model and emb_mem_host_sva are compiled first
`timescale 1ns/100ps
module emb_mem_host_tb;
    localparam int ACC = 1;
    localparam logic [8:0] ID_BASE = 9'h0a5; // arbitrary value
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, bus_oe, read_not_write, write_low_byte_n, write_high_byte_n;
    logic [18:0] mem_addr_n;
    logic [15:0] bus_in_n, bus_out_n;
    logic id_enable_n, slot_select_n, cpu_strobe_n;
    logic [8:0] id_data_n;
    int error_cnt = 0;
    int num_checks = 0;
    always #25 clock = ~clock;
    emb_mem_host #(.ACCESS_CYC(ACC)) uut (.clock, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_addr_n,
        .emu_data_bus_n_in(bus_in_n), .emu_data_bus_n_out(bus_out_n), .emu_data_bus_n_oe(bus_oe),
        .read_not_write, .write_low_byte_n, .write_high_byte_n, .id_enable_n, .slot_select_n,
        .cpu_strobe_n, .id_data_n);
    emb_board_model #(.RANGE(3'h0), .ROWS(4), .ID_BASE(ID_BASE)) board (.mem_addr_n, .bus_out_n,
        .bus_oe, .read_not_write, .write_low_byte_n, .write_high_byte_n, .id_enable_n,
        .slot_select_n, .cpu_strobe_n, .bus_in_n, .id_data_n);
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        // no local limit: only the watchdog may end a wait on the slave
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        av(1'b0, a, 32'h0, 4'hf);
        chk(exp, q);
    endtask
    task automatic go(input logic [1:0] o, input logic [18:0] a, input logic [15:0] d,
                      input logic [1:0] be);
        av(1'b1, emb_pkg::REG_ADDR, {13'h0, a}, 4'hf);
        av(1'b1, emb_pkg::REG_WDATA, {16'h0, d}, 4'hf);
        av(1'b1, emb_pkg::REG_CTRL, {27'h0, be, o, 1'b1}, 4'hf);
    endtask
    // polls done, checks it is sticky with busy gone, then clears it
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            av(1'b0, emb_pkg::REG_STATUS, 32'h0, 4'hf);
            n++;
        end while (q[emb_pkg::STAT_DONE] !== 1'b1 && n < 50);
        rd(emb_pkg::REG_STATUS, 32'h2);
        av(1'b1, emb_pkg::REG_STATUS, 32'h2, 4'h1);
    endtask
    task automatic op(input logic [1:0] o, input logic [18:0] a, input logic [15:0] d,
                      input logic [1:0] be);
        go(o, a, d, be);
        wait_done();
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        chk({6'h0, 19'h7ffff, 7'h3f}, {6'h0, mem_addr_n, bus_oe, read_not_write, write_low_byte_n,
            write_high_byte_n, id_enable_n, slot_select_n, cpu_strobe_n});
        // control reads back its reset lane enables; every other register reads 0
        for (int i = 0; i < 7; i++) begin
            rd(5'(i * 4), (i == 0) ? {27'h0, emb_pkg::RST_BE, 3'h0} : 32'h0);
        end
        av(1'b1, emb_pkg::REG_RDATA, 32'h1234, 4'hf);
        rd(emb_pkg::REG_RDATA, 32'h0);
        av(1'b1, emb_pkg::REG_ADDR, 32'hffffffff, 4'hf);
        rd(emb_pkg::REG_ADDR, 32'h7ffff);
        av(1'b1, emb_pkg::REG_ADDR, 32'h0, 4'h1);
        rd(emb_pkg::REG_ADDR, 32'h7ff00);
        av(1'b1, emb_pkg::REG_WDATA, 32'hffffffff, 4'hf);
        rd(emb_pkg::REG_WDATA, 32'hffff);
        $display("test registers done");
        for (int i = 0; i < 4; i++) op(emb_pkg::EMB_OP_WRITE, {3'h0, 2'(i), 14'h15a5},
            16'(16'h1234 * (i + 1)), 2'h3);
        for (int i = 0; i < 4; i++) begin
            op(emb_pkg::EMB_OP_READ, {3'h0, 2'(i), 14'h15a5}, 16'h0, 2'h3);
            rd(emb_pkg::REG_RDATA, 32'(16'(16'h1234 * (i + 1))));
        end
        rd(emb_pkg::REG_STATUS, 32'h0);
        $display("test rows done");
        op(emb_pkg::EMB_OP_WRITE, 19'h0abcd, 16'ha5c3, 2'h3);
        op(emb_pkg::EMB_OP_WRITE, 19'h0abcd, 16'hff11, 2'h1);
        op(emb_pkg::EMB_OP_READ, 19'h0abcd, 16'h0, 2'h3);
        rd(emb_pkg::REG_RDATA, 32'ha511);
        op(emb_pkg::EMB_OP_WRITE, 19'h0abcd, 16'h22ff, 2'h2);
        op(emb_pkg::EMB_OP_READ, 19'h0abcd, 16'h0, 2'h3);
        rd(emb_pkg::REG_RDATA, 32'h2211);
        $display("test byte lanes done");
        op(emb_pkg::EMB_OP_WRITE, 19'h1abcd, 16'h7777, 2'h3);
        op(emb_pkg::EMB_OP_READ, 19'h1abcd, 16'h0, 2'h3);
        rd(emb_pkg::REG_RDATA, 32'h0);
        $display("test range done");
        go(emb_pkg::EMB_OP_WRITE, 19'h00111, 16'h5a5a, 2'h3);
        av(1'b1, emb_pkg::REG_CTRL, {27'h0, 2'h1, emb_pkg::EMB_OP_READ, 1'b1}, 4'hf);
        wait_done();
        op(emb_pkg::EMB_OP_READ, 19'h00111, 16'h0, 2'h3);
        rd(emb_pkg::REG_RDATA, 32'h5a5a);
        $display("test busy go done");
        op(emb_pkg::EMB_OP_ID, 19'h0, 16'h0, 2'h3);
        rd(emb_pkg::REG_ID, {23'h0, ID_BASE});
        $display("test id done");
        finish_test();
    end
endmodule
